// ---- hw/rf_config_crc_result_regs.sv ----
// Configuration page: checksum result, pulse width, receiver gain, reserved
`include "rf_cfg_consts.svh"

module rf_config_crc_result_regs
  import rf_cfg_pkg::*;
#(
  parameter int ADDR_W = 6,     // Register offset width
  parameter int WIDTH_W = 8     // Pulse width field
)
(
  input wire logic ref_clk_i,              // Device clock
  input wire logic rst_n_i,                // Async reset, active low
  input wire logic [ADDR_W-1:0] addr_i,    // Register offset
  input wire logic [7:0] wdata_i,          // Write data
  input wire logic wr_i,                   // Write strobe
  input wire logic rd_i,                   // Read strobe
  output logic [7:0] rdata_o,              // Read data, cycle after rd_i
  output logic rd_valid_o,                 // Marks the answer cycle
  input wire crc_update_s crc_upd_i,       // Result from checksum engine
  input wire logic miller_start_i,         // Start of one Miller pulse
  output logic miller_pulse_o,             // Modulation pulse
  output logic miller_busy_o,              // Pulse in progress
  output logic [2:0] rx_gain_sel_o,        // Gain code to receiver
  output logic [5:0] rx_gain_db_o          // Decoded gain in dB
);

  // Register state
  logic [7:0] rsvd_20_q;            // Reserved, fixed
  logic [7:0] crc_high_q;           // Checksum high byte
  logic [7:0] crc_low_q;            // Checksum low byte
  logic [7:0] rsvd_23_q;            // Reserved, fixed
  logic [7:0] pulse_width_q;        // Miller pulse width
  logic [7:0] rsvd_25_q;            // Reserved, fixed
  logic [2:0] gain_sel_q;           // Receive gain select
  logic [7:0] rdata_q;              // Read answer
  logic rd_valid_q;                 // Answer marker
  logic [5:0] gain_db_q;            // Decoded gain

  // Strobes qualified by offset
  logic wr_width;                   // Write to pulse width
  logic wr_gain;                    // Write to gain config

  // Gain code to dB; codes 000/010 and 001/011 alias
  function automatic logic [5:0] gain_db(input logic [2:0] code);
    logic [5:0] db;
    db = `GAIN_DB_18;
    unique case (code)
      3'h0: db = `GAIN_DB_18;
      3'h1: db = `GAIN_DB_23;
      3'h2: db = `GAIN_DB_18;
      3'h3: db = `GAIN_DB_23;
      3'h4: db = `GAIN_DB_33;
      3'h5: db = `GAIN_DB_38;
      3'h6: db = `GAIN_DB_43;
      3'h7: db = `GAIN_DB_48;
    endcase
    return db;
  endfunction : gain_db

  // Full gain register image with reserved bits fixed
  function automatic logic [7:0] gain_image(input logic [2:0] sel);
    logic [7:0] img;
    img = `GAIN_RSVD_FIXED;
    img[`GAIN_MSB:`GAIN_LSB] = sel;
    return img;
  endfunction : gain_image

  // Offset decode of the read path
  function automatic logic [7:0] read_mux(
    input logic [ADDR_W-1:0] ofs,
    input logic [7:0] r20,
    input logic [7:0] chi,
    input logic [7:0] clo,
    input logic [7:0] r23,
    input logic [7:0] pw,
    input logic [7:0] r25,
    input logic [2:0] gs
  );
    logic [7:0] v;
    v = `RDATA_IDLE;
    case (ofs)
      `OFS_RSVD_20: v = r20;
      `OFS_CRC_HIGH: v = chi;
      `OFS_CRC_LOW: v = clo;
      `OFS_RSVD_23: v = r23;
      `OFS_PULSE_WIDTH: v = pw;
      `OFS_RSVD_25: v = r25;
      `OFS_GAIN_CFG: v = gain_image(gs);
      // Unmapped offsets read as zero
      default: v = `RDATA_IDLE;
    endcase
    return v;
  endfunction : read_mux

  // Write decode; only two offsets accept writes
  assign wr_width = wr_i && (addr_i == `OFS_PULSE_WIDTH);
  assign wr_gain = wr_i && (addr_i == `OFS_GAIN_CFG);

  // Reserved registers: reset values, never written
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rsvd_20_q <= `RST_RSVD_20;
      rsvd_23_q <= `RST_RSVD_23;
      rsvd_25_q <= `RST_RSVD_25;
    end
    else
    begin
      // Host writes have no effect here
      rsvd_20_q <= rsvd_20_q;
      rsvd_23_q <= rsvd_23_q;
      rsvd_25_q <= rsvd_25_q;
    end
  end

  // Checksum result: loaded only by the engine, host writes dropped
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      crc_high_q <= `RST_CRC_HIGH;
      crc_low_q <= `RST_CRC_LOW;
    end
    else if (crc_upd_i.load)
    begin
      // Engine result splits into MSB and LSB bytes
      crc_high_q <= crc_upd_i.value[15:8];
      crc_low_q <= crc_upd_i.value[7:0];
    end
  end

  // Pulse width: plain read/write byte
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pulse_width_q <= `RST_PULSE_WIDTH;
    end
    else if (wr_width)
    begin
      // Host keeps this within half a bit period
      pulse_width_q <= wdata_i;
    end
  end

  // Gain select: only the field is stored, reserved bits stay fixed
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      // Gain field of the register reset image
      gain_sel_q <= `RST_GAIN_SEL;
    end
    else if (wr_gain)
    begin
      gain_sel_q <= wdata_i[`GAIN_MSB:`GAIN_LSB];
    end
  end

  // Read answer stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_q <= `RDATA_IDLE;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= rd_i;
      if (rd_i)
      begin
        rdata_q <= read_mux(addr_i, rsvd_20_q, crc_high_q, crc_low_q,
                            rsvd_23_q, pulse_width_q, rsvd_25_q, gain_sel_q);
      end
      else
      begin
        // Quiet between answers
        rdata_q <= `RDATA_IDLE;
      end
    end
  end

  // Decoded gain to the receiver front end
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gain_db_q <= `GAIN_DB_33;
    end
    else
    begin
      gain_db_q <= gain_db(gain_sel_q);
    end
  end

  // Miller pulse timer fed from the width register
  miller_pulse_gen #(
    .WIDTH_W(WIDTH_W)
  ) u_pulse (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .req_i('{start: miller_start_i, width: pulse_width_q}),
    .pulse_o(miller_pulse_o),
    .busy_o(miller_busy_o)
  );

  // Outputs
  assign rdata_o = rdata_q;
  assign rd_valid_o = rd_valid_q;
  assign rx_gain_sel_o = gain_sel_q;
  assign rx_gain_db_o = gain_db_q;

  // Checks on the register behaviour
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Read of a given offset, answered next cycle
  sequence s_read(logic [ADDR_W-1:0] ofs);
    rd_i && (addr_i == ofs);
  endsequence

  // Write of a given offset
  sequence s_write(logic [ADDR_W-1:0] ofs);
    wr_i && (addr_i == ofs);
  endsequence

  // Checksum result bytes and their read path
  chk_crc_high_read: assert property (
    s_read(`OFS_CRC_HIGH) |=> (rdata_o == $past(crc_high_q)) && rd_valid_o)
    else $error("High checksum byte read mismatch");

  chk_crc_low_read: assert property (
    s_read(`OFS_CRC_LOW) |=> (rdata_o == $past(crc_low_q)) && rd_valid_o)
    else $error("Low checksum byte read mismatch");

  chk_crc_load_split: assert property (
    crc_upd_i.load |=> (crc_high_q == $past(crc_upd_i.value[15:8]))
      && (crc_low_q == $past(crc_upd_i.value[7:0])))
    else $error("Checksum result not split into bytes");

  chk_crc_ro_write: assert property (
    (s_write(`OFS_CRC_HIGH) or s_write(`OFS_CRC_LOW)) and !crc_upd_i.load
      |=> $stable(crc_high_q) && $stable(crc_low_q))
    else $error("Host write changed checksum result");

  // Width written and read back with no gap between the strobes
  sequence s_width_b2b;
    s_write(`OFS_PULSE_WIDTH) ##1 (s_read(`OFS_PULSE_WIDTH) and !wr_i);
  endsequence

  chk_width_write_read: assert property (
    s_width_b2b |=> rdata_o == $past(wdata_i, 2))
    else $error("Pulse width readback mismatch");

  chk_gain_write_mask: assert property (
    s_write(`OFS_GAIN_CFG)
      |=> gain_image(gain_sel_q) == (($past(wdata_i) & `GAIN_FIELD_MASK)
        | `GAIN_RSVD_FIXED))
    else $error("Gain register reserved bits not fixed");

  chk_gain_decode: assert property (
    $stable(gain_sel_q) && !gain_sel_q[2]
      |-> rx_gain_db_o == (gain_sel_q[0] ? `GAIN_DB_23 : `GAIN_DB_18))
    else $error("Gain decode wrong for low codes");

  chk_gain_decode_high: assert property (
    $stable(gain_sel_q) && gain_sel_q[2]
      |-> rx_gain_db_o == 6'(`GAIN_DB_33 + 6'd5 * gain_sel_q[1:0]))
    else $error("Gain decode wrong for high codes");

  // Reserved registers hold their reset values
  chk_rsvd_values: assert property (
    s_read(`OFS_RSVD_23) |=> rdata_o == `RST_RSVD_23)
    else $error("Reserved register value changed");

  chk_rsvd_stable: assert property (
    rsvd_20_q == `RST_RSVD_20 && rsvd_25_q == `RST_RSVD_25)
    else $error("Reserved register left its reset value");

  chk_rdata_idle: assert property (
    !rd_i |=> (rdata_o == `RDATA_IDLE) && !rd_valid_o)
    else $error("Read data outside answer cycle");

  chk_pulse_start: assert property (
    miller_start_i && !miller_busy_o |=> miller_pulse_o)
    else $error("Miller pulse did not start");

  // Reads outside the page answer zero but still mark the answer cycle
  sequence s_read_unmapped;
    rd_i && ((addr_i < `OFS_RSVD_20) || (addr_i > `OFS_GAIN_CFG));
  endsequence

  chk_unmapped_read: assert property (
    s_read_unmapped |=> (rdata_o == `RDATA_IDLE) && rd_valid_o)
    else $error("Unmapped offset did not read as zero");

  chk_read_valid: assert property (
    rd_i |=> rd_valid_o)
    else $error("Answer marker missing after read strobe");

  // Reserved registers 20 and 25 read their fixed values on every read
  chk_rsvd_20_read: assert property (
    s_read(`OFS_RSVD_20) |=> rdata_o == `RST_RSVD_20)
    else $error("Reserved register 20 read wrong value");

  chk_rsvd_25_read: assert property (
    s_read(`OFS_RSVD_25) |=> rdata_o == `RST_RSVD_25)
    else $error("Reserved register 25 read wrong value");

  // Gain register reads back fixed reserved bits whatever was written
  chk_gain_rsvd_bits: assert property (
    s_read(`OFS_GAIN_CFG) |=> (rdata_o & ~`GAIN_FIELD_MASK) == `GAIN_RSVD_FIXED)
    else $error("Gain register reserved bits read wrong");

  // Stored values move only on their own write or load
  chk_width_hold: assert property (
    !(wr_i && (addr_i == `OFS_PULSE_WIDTH)) |=> $stable(pulse_width_q))
    else $error("Pulse width changed without a write");

  chk_gain_hold: assert property (
    !(wr_i && (addr_i == `OFS_GAIN_CFG)) |=> $stable(gain_sel_q))
    else $error("Gain select changed without a write");

  chk_crc_hold: assert property (
    !crc_upd_i.load |=> $stable(crc_high_q) && $stable(crc_low_q))
    else $error("Checksum result changed without a load");

  // No pulse appears unless one was asked for
  chk_pulse_unasked: assert property (
    !miller_busy_o && !miller_start_i |=> !miller_pulse_o)
    else $error("Miller pulse started without a request");

endmodule : rf_config_crc_result_regs

// ---- hw/rf_cfg_consts.svh ----
// Offsets, reset values, field positions and gain figures of the config page
`ifndef RF_CFG_CONSTS_SVH
`define RF_CFG_CONSTS_SVH

// Register offsets within the page
`define OFS_RSVD_20 6'h20
`define OFS_CRC_HIGH 6'h21
`define OFS_CRC_LOW 6'h22
`define OFS_RSVD_23 6'h23
`define OFS_PULSE_WIDTH 6'h24
`define OFS_RSVD_25 6'h25
`define OFS_GAIN_CFG 6'h26

// Reset values
`define RST_RSVD_20 8'h00
`define RST_CRC_HIGH 8'hff
`define RST_CRC_LOW 8'hff
`define RST_RSVD_23 8'h88
`define RST_PULSE_WIDTH 8'h26
`define RST_RSVD_25 8'h87
`define RST_GAIN_CFG 8'h48
`define RST_GAIN_SEL 3'h4

// Gain field position and fixed reserved bits
`define GAIN_MSB 6
`define GAIN_LSB 4
`define GAIN_FIELD_MASK 8'h70
`define GAIN_RSVD_FIXED 8'h08

// Gain figures in dB
`define GAIN_DB_18 6'h12
`define GAIN_DB_23 6'h17
`define GAIN_DB_33 6'h21
`define GAIN_DB_38 6'h26
`define GAIN_DB_43 6'h2b
`define GAIN_DB_48 6'h30

// Read data outside the answer cycle or for unmapped offsets
`define RDATA_IDLE 8'h00

`endif

// ---- hw/rf_cfg_pkg.sv ----
// Types shared by the configuration page and the pulse generator
package rf_cfg_pkg;

  // Checksum result handed over by the checksum engine
  typedef struct packed {
    logic load;          // One-cycle strobe, result valid
    logic [15:0] value;  // Full 16-bit result
  } crc_update_s;

  // Request for one Miller modulation pulse
  typedef struct packed {
    logic start;         // One-cycle start strobe
    logic [7:0] width;   // Programmed pulse width
  } miller_req_s;

  // Pulse generator states
  typedef enum logic {
    PULSE_IDLE,
    PULSE_ACTIVE
  } pulse_state_e;

endpackage : rf_cfg_pkg

// ---- hw/miller_pulse_gen.sv ----
// Miller modulation pulse timer, width plus one carrier cycles long
module miller_pulse_gen
  import rf_cfg_pkg::*;
#(
  parameter int WIDTH_W = 8  // Width of the pulse count
)
(
  input wire logic ref_clk_i,         // Carrier-rate clock
  input wire logic rst_n_i,           // Async reset, active low
  input wire miller_req_s req_i,      // Start strobe and width
  output logic pulse_o,               // Modulation pulse
  output logic busy_o                 // Pulse in progress
);

  pulse_state_e state_q;              // Current state
  logic [WIDTH_W-1:0] cnt_q;          // Remaining cycles minus one

  // State walk: start only from idle, leave when count is spent
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= PULSE_IDLE;
    end
    else
    begin
      unique case (state_q)
        PULSE_IDLE:
        begin
          // New pulse
          if (req_i.start)
          begin
            state_q <= PULSE_ACTIVE;
          end
        end
        PULSE_ACTIVE:
        begin
          // Last cycle of the pulse
          if (cnt_q == '0)
          begin
            state_q <= PULSE_IDLE;
          end
        end
      endcase
    end
  end

  // Width is latched at start, so a rewrite mid-pulse cannot stretch it
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= '0;
    end
    else if (state_q == PULSE_IDLE && req_i.start)
    begin
      cnt_q <= req_i.width[WIDTH_W-1:0];
    end
    else if (state_q == PULSE_ACTIVE && cnt_q != '0)
    begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // Pulse is high for width plus one cycles
  assign pulse_o = (state_q == PULSE_ACTIVE);
  assign busy_o = pulse_o;

  // Helper: measured length and latched width plus one
  logic [WIDTH_W:0] len_q;
  logic [WIDTH_W:0] want_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      len_q <= '0;
      want_q <= '0;
    end
    else if (state_q == PULSE_IDLE && req_i.start)
    begin
      len_q <= '0;
      want_q <= {1'b0, req_i.width[WIDTH_W-1:0]} + 1'b1;
    end
    else if (pulse_o)
    begin
      len_q <= len_q + 1'b1;
    end
  end

  chk_pulse_length: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    $fell(pulse_o) |-> (len_q == want_q))
    else $error("Miller pulse length differs from width plus one");

endmodule : miller_pulse_gen

// ---- testbench/rf_config_crc_result_regs_test.sv ----
// Self-checking bench for the configuration register page
module rf_config_crc_result_regs_test
  import rf_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk_i; // Device clock, 50 ns
  logic rst_n_i; // Async reset, active low
  logic [5:0] addr_i; // Register offset
  logic [7:0] wdata_i; // Write data
  logic wr_i; // Write strobe
  logic rd_i; // Read strobe
  logic [7:0] rdata_o; // Read answer
  logic rd_valid_o; // Answer marker
  crc_update_s crc_upd_i; // Checksum result input
  logic miller_start_i; // Pulse start
  logic miller_pulse_o; // Modulation pulse
  logic miller_busy_o; // Pulse in progress
  logic [2:0] rx_gain_sel_o; // Gain code
  logic [5:0] rx_gain_db_o; // Decoded gain
  int bad_count; // Mismatches seen
  int cmp_count; // Comparisons made

  // Device under test, default widths
  rf_config_crc_result_regs dut (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .rd_valid_o(rd_valid_o),
    .crc_upd_i(crc_upd_i),
    .miller_start_i(miller_start_i),
    .miller_pulse_o(miller_pulse_o),
    .miller_busy_o(miller_busy_o),
    .rx_gain_sel_o(rx_gain_sel_o),
    .rx_gain_db_o(rx_gain_db_o)
  );

  // Free-running clock
  always #25 ref_clk_i = ~ref_clk_i;

  // One comparison, reported at once on mismatch
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Verdict and end of run
  task automatic print_verdict();
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // One-cycle write strobe
  task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : reg_write

  // One-cycle read; answer only in the next cycle, idle after it
  task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
    check("read valid", 8'h01, {7'h0, rd_valid_o});
    @(posedge ref_clk_i);
    #1;
    check("idle data", 8'h00, rdata_o);
    check("idle valid", 8'h00, {7'h0, rd_valid_o});
  endtask : reg_read

  // Reset for four cycles, outputs checked while held
  task automatic apply_reset();
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    check("gain code in reset", 8'h04, {5'h0, rx_gain_sel_o});
    check("gain dB in reset", 8'h21, {2'h0, rx_gain_db_o});
    check("pulse in reset", 8'h00, {7'h0, miller_pulse_o});
    check("busy in reset", 8'h00, {7'h0, miller_busy_o});
    check("data in reset", 8'h00, rdata_o);
    check("valid in reset", 8'h00, {7'h0, rd_valid_o});
    @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
  endtask : apply_reset

  // All seven registers against their reset values
  task automatic reset_table();
    logic [7:0] tab [7];
    logic [7:0] d;
    tab = '{8'h00, 8'hff, 8'hff, 8'h88, 8'h26, 8'h87, 8'h48};
    for (int i = 0; i < 7; i++)
    begin
      reg_read(6'(6'h20 + i), d);
      check("reset value", tab[i], d);
    end
  endtask : reset_table

  // Writes to read-only, reserved and unmapped places
  task automatic ignored_writes();
    logic [5:0] ofs [6];
    logic [7:0] d;
    ofs = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h25, 6'h27};
    foreach (ofs[i])
      reg_write(ofs[i], 8'h5a);
    reg_read(6'h27, d);
    check("unmapped above", 8'h00, d);
    reg_read(6'h1f, d);
    check("unmapped below", 8'h00, d);
  endtask : ignored_writes

  // Checksum loads, single and back to back, then host writes refused
  task automatic crc_scenario();
    logic [7:0] d;
    @(posedge ref_clk_i);
    crc_upd_i <= {1'b1, 16'h1234};
    @(posedge ref_clk_i);
    crc_upd_i <= {1'b0, 16'h5555};
    reg_read(6'h21, d);
    check("checksum high", 8'h12, d);
    reg_read(6'h22, d);
    check("checksum low", 8'h34, d);
    @(posedge ref_clk_i);
    crc_upd_i <= {1'b1, 16'h0f0f};
    @(posedge ref_clk_i);
    crc_upd_i <= {1'b1, 16'habcd};
    @(posedge ref_clk_i);
    crc_upd_i <= {1'b0, 16'h6666};
    reg_write(6'h21, 8'h00);
    reg_write(6'h22, 8'h00);
    reg_read(6'h21, d);
    check("checksum high kept", 8'hab, d);
    reg_read(6'h22, d);
    check("checksum low kept", 8'hcd, d);
  endtask : crc_scenario

  // Every gain code, reserved bits written inverted
  task automatic gain_scenario();
    logic [7:0] db [8];
    logic [7:0] d;
    db = '{8'h12, 8'h17, 8'h12, 8'h17, 8'h21, 8'h26, 8'h2b, 8'h30};
    for (int c = 0; c < 8; c++)
    begin
      reg_write(6'h26, {1'b1, 3'(c), 4'h7});
      reg_read(6'h26, d);
      check("gain readback", {1'b0, 3'(c), 4'h8}, d);
      check("gain code", 8'(c), {5'h0, rx_gain_sel_o});
      check("gain dB", db[c], {2'h0, rx_gain_db_o});
    end
  endtask : gain_scenario

  // Program a width, fire one pulse, optionally poke start mid-pulse
  task automatic pulse_run(input logic [7:0] w, input bit poke);
    logic [7:0] d;
    int n;
    reg_write(6'h24, w);
    reg_read(6'h24, d);
    check("width readback", w, d);
    @(posedge ref_clk_i);
    miller_start_i <= 1'b1;
    @(posedge ref_clk_i);
    miller_start_i <= 1'b0;
    #1;
    n = 0;
    while (miller_pulse_o === 1'b1 && n < 300)
    begin
      check("busy in pulse", 8'h01, {7'h0, miller_busy_o});
      n++;
      @(posedge ref_clk_i);
      miller_start_i <= (poke && n == 1);
      #1;
    end
    if (n >= 300)
    begin
      bad_count++;
      print_verdict();
    end
    else
    begin
      check("pulse length", w + 8'h01, 8'(n));
      @(posedge ref_clk_i);
      #1;
      check("no restart", 8'h00, {7'h0, miller_pulse_o});
      check("busy after", 8'h00, {7'h0, miller_busy_o});
    end
  endtask : pulse_run

  // Width write, its read and a gain read, strobes with no gap
  task automatic back_to_back();
    @(posedge ref_clk_i);
    addr_i <= 6'h24;
    wdata_i <= 8'h3c;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    addr_i <= 6'h26;
    #1;
    check("b2b width", 8'h3c, rdata_o);
    check("b2b width valid", 8'h01, {7'h0, rd_valid_o});
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    check("b2b gain", 8'h78, rdata_o);
    check("b2b gain valid", 8'h01, {7'h0, rd_valid_o});
    @(posedge ref_clk_i);
    #1;
    check("b2b idle", 8'h00, rdata_o);
  endtask : back_to_back

  // Main sequence
  initial
  begin
    ref_clk_i = 1'b0;
    rst_n_i = 1'b0;
    addr_i = 6'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    crc_upd_i = '0;
    miller_start_i = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    apply_reset();
    reset_table();
    ignored_writes();
    reset_table();
    crc_scenario();
    gain_scenario();
    pulse_run(8'h00, 1'b0);
    pulse_run(8'h02, 1'b1);
    pulse_run(8'h05, 1'b0);
    back_to_back();
    apply_reset();
    reset_table();
    print_verdict();
  end

endmodule : rf_config_crc_result_regs_test
